/* rtl/apf_dev.sv */
// Function
// - Byte bus, two strobes, two low flags
// - Host reads only while receive flag low
// - Host writes only while space flag low
// - Write strobe fall captures bus byte
// - Drive byte from a cycle after read strobe fall to a cycle after its rise
// - Read strobe fall advances receive buffer
// - Output enable follows read strobe internally
// - Receive flag high after read, low on byte
// - Write fall raises space flag; low if room
// - Receive flag high 100 ns after read
// - Read strobe not before receive flag
// - Write strobe not before space flag
// - Read strobe low at least 30 ns
`timescale 1ns/100ps
`include "apf_regs.svh"

module apf_dev (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // Parallel port pins
  apf_if.dev                          port,
  // Bytes written by the host
  output logic      [`APF_DATA_W-1:0] tx_data,
  output logic                        tx_valid,
  input  wire logic                   tx_ready,
  // Bytes for the host to read
  input  wire logic [`APF_DATA_W-1:0] rx_data,
  input  wire logic                   rx_valid,
  output logic                        rx_ready
);

  // Strobe history for edge detection
  logic                         rd_prev_reg;
  logic                         wr_prev_reg;
  logic                         rd_fall;
  logic                         rd_rise;
  logic                         wr_fall;

  // Receive side
  apf_pkg::apf_rx_state_t       rx_state_reg;
  apf_pkg::apf_rx_state_t       rx_state_next;
  logic [`APF_CNT_W-1:0]        hold_cnt_reg;
  logic [`APF_CNT_W-1:0]        hold_cnt_next;
  logic [`APF_DATA_W-1:0]       dout_reg;
  logic [`APF_DATA_W-1:0]       dout_next;
  logic                         oe_reg;
  logic                         oe_next;
  logic                         rxf_n_reg;
  logic                         rxf_n_next;
  logic                         rx_pop;
  logic [`APF_DATA_W-1:0]       rx_head;
  logic                         rx_head_valid;
  logic                         rx_in_ready;

  // Transmit side
  logic                         txe_n_reg;
  logic                         txe_n_next;
  logic                         tx_in_ready;
  logic [`APF_DATA_W-1:0]       tx_out_data;
  logic                         tx_out_valid;

  // Edge detection on the host strobes
  always_comb begin
    rd_fall = rd_prev_reg && !port.rd_n;
    rd_rise = !rd_prev_reg && port.rd_n;
    wr_fall = wr_prev_reg && !port.wr_n;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_prev_reg <= 1'b1;
      wr_prev_reg <= 1'b1;
    end else begin
      rd_prev_reg <= port.rd_n;
      wr_prev_reg <= port.wr_n;
    end
  end

  // Receive buffer, filled by the user side
  apf_fifo #(
    .WIDTH (`APF_DATA_W),
    .DEPTH (`APF_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_data   (rx_data),
    .in_valid  (rx_valid),
    .in_ready  (rx_in_ready),
    .out_data  (rx_head),
    .out_valid (rx_head_valid),
    .out_ready (rx_pop)
  );

  // Transmit buffer, drained by the user side
  apf_fifo #(
    .WIDTH (`APF_DATA_W),
    .DEPTH (`APF_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_data   (port.data_bus),
    .in_valid  (wr_fall),
    .in_ready  (tx_in_ready),
    .out_data  (tx_out_data),
    .out_valid (tx_out_valid),
    .out_ready (tx_ready)
  );

  // Receive sequencing and flag
  always_comb begin
    rx_state_next = rx_state_reg;
    hold_cnt_next = hold_cnt_reg;
    dout_next     = dout_reg;
    // Pop only when a byte exists
    rx_pop        = rd_fall && rx_head_valid;
    if (rx_pop) begin
      dout_next = rx_head;
    end
    if (rd_fall) begin
      rx_state_next = apf_pkg::APF_RX_BUSY;
    end else begin
      unique case (rx_state_reg)
        apf_pkg::APF_RX_WAIT: begin
          if (rx_head_valid) begin
            rx_state_next = apf_pkg::APF_RX_READY;
          end
        end
        apf_pkg::APF_RX_READY: begin
          rx_state_next = apf_pkg::APF_RX_READY;
        end
        apf_pkg::APF_RX_BUSY: begin
          if (rd_rise) begin
            rx_state_next = apf_pkg::APF_RX_HOLD;
            hold_cnt_next = '0;
          end
        end
        apf_pkg::APF_RX_HOLD: begin
          // Keep the flag high for the minimum recovery
          if (hold_cnt_reg == `APF_CNT_W'(`APF_RXF_HOLD_CYC - 1)) begin
            rx_state_next = apf_pkg::APF_RX_WAIT;
          end else begin
            hold_cnt_next = `APF_CNT_W'(hold_cnt_reg + 1'b1);
          end
        end
      endcase
    end
    // Flag low only while a byte stands ready
    rxf_n_next = (rx_state_next != apf_pkg::APF_RX_READY);
    // Drive the bus from one cycle after the strobe falls to one cycle after it rises
    oe_next    = !port.rd_n;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_state_reg <= apf_pkg::APF_RX_WAIT;
      hold_cnt_reg <= '0;
      dout_reg     <= '0;
      oe_reg       <= 1'b0;
      rxf_n_reg    <= 1'b1;
    end else begin
      rx_state_reg <= rx_state_next;
      hold_cnt_reg <= hold_cnt_next;
      dout_reg     <= dout_next;
      oe_reg       <= oe_next;
      rxf_n_reg    <= rxf_n_next;
    end
  end

  // Transmit flag
  always_comb begin
    // High on every fall; low only with the strobe high and room
    txe_n_next = wr_fall || !port.wr_n || !tx_in_ready;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txe_n_reg <= 1'b1;
    end else begin
      txe_n_reg <= txe_n_next;
    end
  end

  // Pin drive
  always_comb begin
    port.data_dev    = dout_reg;
    port.data_dev_oe = oe_reg;
    port.rxf_n       = rxf_n_reg;
    port.txe_n       = txe_n_reg;
  end

  // User side
  always_comb begin
    tx_data  = tx_out_data;
    tx_valid = tx_out_valid;
    rx_ready = rx_in_ready;
  end

endmodule : apf_dev

/* rtl/apf_regs.svh */
`ifndef APF_REGS_SVH
`define APF_REGS_SVH

// Data path and buffering
`define APF_DATA_W       8
`define APF_FIFO_DEPTH   16
`define APF_CNT_W        4

// Clock and timing
`define APF_CLK_NS       10
`define APF_RXF_HOLD_NS  100
`define APF_RXF_HOLD_CYC ((`APF_RXF_HOLD_NS + `APF_CLK_NS - 1) / `APF_CLK_NS)
`define APF_RD_LOW_NS    30
`define APF_RD_LOW_CYC   ((`APF_RD_LOW_NS + `APF_CLK_NS - 1) / `APF_CLK_NS)
`define APF_WR_LOW_CYC   `APF_RD_LOW_CYC
`define APF_RECOVER_CYC  2

`endif

/* rtl/apf_pkg.sv */
package apf_pkg;

  typedef enum logic [1:0] {
    APF_RX_WAIT  = 2'b00,
    APF_RX_READY = 2'b01,
    APF_RX_BUSY  = 2'b10,
    APF_RX_HOLD  = 2'b11
  } apf_rx_state_t;

  typedef enum logic [2:0] {
    APF_H_IDLE     = 3'b000,
    APF_H_RD_LOW   = 3'b001,
    APF_H_RD_END   = 3'b010,
    APF_H_WR_SETUP = 3'b011,
    APF_H_WR_LOW   = 3'b100,
    APF_H_WR_END   = 3'b101
  } apf_host_state_t;

endpackage : apf_pkg

/* rtl/apf_if.sv */
`timescale 1ns/100ps
`include "apf_regs.svh"

interface apf_if;
  logic [`APF_DATA_W-1:0] data_dev;
  logic                   data_dev_oe;
  logic [`APF_DATA_W-1:0] data_host;
  logic                   data_host_oe;
  logic [`APF_DATA_W-1:0] data_bus;
  logic                   rd_n;
  logic                   wr_n;
  logic                   rxf_n;
  logic                   txe_n;

  // Shared bus level from the two enables
  assign data_bus = data_dev_oe  ? data_dev  :
                    data_host_oe ? data_host : '0;

  modport dev (
    input  data_bus,
    input  rd_n,
    input  wr_n,
    output data_dev,
    output data_dev_oe,
    output rxf_n,
    output txe_n
  );

  modport host (
    input  data_bus,
    input  rxf_n,
    input  txe_n,
    output data_host,
    output data_host_oe,
    output rd_n,
    output wr_n
  );
endinterface : apf_if

/* rtl/apf_fifo.sv */
`timescale 1ns/100ps
`include "apf_regs.svh"

module apf_fifo #(
  parameter int WIDTH = `APF_DATA_W,
  parameter int DEPTH = `APF_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    wr_ptr_next;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW-1:0]    rd_ptr_next;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];

  always_comb begin
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    wr_ptr_next = push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
    rd_ptr_next = pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
    count_next  = count_reg;
    if (push && !pop) begin
      count_next = (AW+1)'(count_reg + 1'b1);
    end else if (pop && !push) begin
      count_next = (AW+1)'(count_reg - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  // Storage needs no reset; a full buffer refuses the write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
endmodule : apf_fifo

/* rtl/apf_host.sv */
`timescale 1ns/100ps
`include "apf_regs.svh"

module apf_host (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // Parallel port pins
  apf_if.host                         port,
  // Bytes to write into the device
  input  wire logic [`APF_DATA_W-1:0] tx_data,
  input  wire logic                   tx_valid,
  output logic                        tx_ready,
  // Bytes read from the device
  output logic      [`APF_DATA_W-1:0] rx_data,
  output logic                        rx_valid,
  input  wire logic                   rx_ready
);

  apf_pkg::apf_host_state_t state_reg;
  apf_pkg::apf_host_state_t state_next;
  logic [`APF_CNT_W-1:0]    cnt_reg;
  logic [`APF_CNT_W-1:0]    cnt_next;
  logic                     rd_n_reg;
  logic                     rd_n_next;
  logic                     wr_n_reg;
  logic                     wr_n_next;
  logic                     oe_reg;
  logic                     oe_next;
  logic [`APF_DATA_W-1:0]   dout_reg;
  logic [`APF_DATA_W-1:0]   dout_next;
  logic                     have_tx_reg;
  logic                     have_tx_next;
  logic                     tx_ready_reg;
  logic                     tx_ready_next;
  logic [`APF_DATA_W-1:0]   rx_data_reg;
  logic [`APF_DATA_W-1:0]   rx_data_next;
  logic                     rx_valid_reg;
  logic                     rx_valid_next;

  always_comb begin
    state_next    = state_reg;
    cnt_next      = `APF_CNT_W'(cnt_reg + 1'b1);
    rd_n_next     = rd_n_reg;
    wr_n_next     = wr_n_reg;
    oe_next       = oe_reg;
    dout_next     = dout_reg;
    have_tx_next  = have_tx_reg;
    rx_data_next  = rx_data_reg;
    rx_valid_next = rx_valid_reg && !rx_ready;
    if (tx_valid && tx_ready_reg) begin
      dout_next    = tx_data;
      have_tx_next = 1'b1;
    end
    unique case (state_reg)
      apf_pkg::APF_H_IDLE: begin
        cnt_next = '0;
        // Read only on a low flag
        if (!port.rxf_n && !rx_valid_reg) begin
          state_next = apf_pkg::APF_H_RD_LOW;
          rd_n_next  = 1'b0;
        end else if (have_tx_reg && !port.txe_n) begin
          state_next = apf_pkg::APF_H_WR_SETUP;
          oe_next    = 1'b1;
        end
      end
      apf_pkg::APF_H_RD_LOW: begin
        // Strobe held for the minimum width
        if (cnt_reg == `APF_CNT_W'(`APF_RD_LOW_CYC - 1)) begin
          state_next    = apf_pkg::APF_H_RD_END;
          cnt_next      = '0;
          rd_n_next     = 1'b1;
          rx_data_next  = port.data_bus;
          rx_valid_next = 1'b1;
        end
      end
      apf_pkg::APF_H_RD_END: begin
        if (cnt_reg == `APF_CNT_W'(`APF_RECOVER_CYC - 1)) begin
          state_next = apf_pkg::APF_H_IDLE;
        end
      end
      apf_pkg::APF_H_WR_SETUP: begin
        state_next = apf_pkg::APF_H_WR_LOW;
        cnt_next   = '0;
        wr_n_next  = 1'b0;
      end
      apf_pkg::APF_H_WR_LOW: begin
        if (cnt_reg == `APF_CNT_W'(`APF_WR_LOW_CYC - 1)) begin
          state_next   = apf_pkg::APF_H_WR_END;
          cnt_next     = '0;
          wr_n_next    = 1'b1;
          have_tx_next = 1'b0;
        end
      end
      apf_pkg::APF_H_WR_END: begin
        oe_next = 1'b0;
        if (cnt_reg == `APF_CNT_W'(`APF_RECOVER_CYC - 1)) begin
          state_next = apf_pkg::APF_H_IDLE;
        end
      end
      default: begin
        state_next = apf_pkg::APF_H_IDLE;
        rd_n_next  = 1'b1;
        wr_n_next  = 1'b1;
        oe_next    = 1'b0;
      end
    endcase
    tx_ready_next = !have_tx_next && !(tx_valid && tx_ready_reg);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg    <= apf_pkg::APF_H_IDLE;
      cnt_reg      <= '0;
      rd_n_reg     <= 1'b1;
      wr_n_reg     <= 1'b1;
      oe_reg       <= 1'b0;
      dout_reg     <= '0;
      have_tx_reg  <= 1'b0;
      tx_ready_reg <= 1'b0;
      rx_data_reg  <= '0;
      rx_valid_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      rd_n_reg     <= rd_n_next;
      wr_n_reg     <= wr_n_next;
      oe_reg       <= oe_next;
      dout_reg     <= dout_next;
      have_tx_reg  <= have_tx_next;
      tx_ready_reg <= tx_ready_next;
      rx_data_reg  <= rx_data_next;
      rx_valid_reg <= rx_valid_next;
    end
  end

  always_comb begin
    port.rd_n         = rd_n_reg;
    port.wr_n         = wr_n_reg;
    port.data_host    = dout_reg;
    port.data_host_oe = oe_reg;
    tx_ready          = tx_ready_reg;
    rx_data           = rx_data_reg;
    rx_valid          = rx_valid_reg;
  end
endmodule : apf_host

/* verif/apf_checker.sv */
`timescale 1ns/100ps
`include "apf_regs.svh"

module apf_checker (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   sys_rst,
  // Port signals
  input wire logic [`APF_DATA_W-1:0] data_dev,
  input wire logic                   data_dev_oe,
  input wire logic [`APF_DATA_W-1:0] data_host,
  input wire logic                   data_host_oe,
  input wire logic [`APF_DATA_W-1:0] data_bus,
  input wire logic                   rd_n,
  input wire logic                   wr_n,
  input wire logic                   rxf_n,
  input wire logic                   txe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_oe_follow; data_dev_oe == !$past(rd_n); endproperty
  a_oe_follow: assert property (p_oe_follow)
    else $error("bus enable not following read strobe");
  property p_rd_flag; !rd_n |=> rxf_n; endproperty
  a_rd_flag: assert property (p_rd_flag)
    else $error("receive flag low during read");
  property p_rxf_hold; $rose(rd_n) |-> rxf_n[*8] ##1 rxf_n[*2]; endproperty
  a_rxf_hold: assert property (p_rxf_hold)
    else $error("receive flag back too early");
  property p_wr_flag; !wr_n |=> txe_n; endproperty
  a_wr_flag: assert property (p_wr_flag)
    else $error("space flag low during write");
  property p_no_clash; !(data_dev_oe && data_host_oe); endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive the bus");
  property p_dev_steady;
    data_dev_oe && $past(data_dev_oe) |-> $stable(data_dev);
  endproperty
  a_dev_steady: assert property (p_dev_steady)
    else $error("read byte moved while driven");
  property p_dev_moves;
    $changed(data_dev) |-> !$past(rd_n) && $past(rd_n, 2);
  endproperty
  a_dev_moves: assert property (p_dev_moves)
    else $error("read byte moved without strobe fall");
  property p_rd_ok; $fell(rd_n) |-> !$past(rxf_n); endproperty
  a_rd_ok: assert property (p_rd_ok)
    else $error("read without receive flag");
  property p_wr_ok; $fell(wr_n) |-> !$past(txe_n); endproperty
  a_wr_ok: assert property (p_wr_ok)
    else $error("write without space flag");
  property p_rd_width; $fell(rd_n) |-> !rd_n[*3]; endproperty
  a_rd_width: assert property (p_rd_width)
    else $error("read strobe too short");
  property p_rd_after; $fell(rxf_n) |-> rd_n; endproperty
  a_rd_after: assert property (p_rd_after)
    else $error("read strobe low before receive flag");
  property p_wr_after; $fell(txe_n) |-> wr_n; endproperty
  a_wr_after: assert property (p_wr_after)
    else $error("write strobe low before space flag");
  property p_wr_data;
    !wr_n |-> data_host_oe && (data_bus == data_host);
  endproperty
  a_wr_data: assert property (p_wr_data)
    else $error("write byte not on the bus during strobe");
endmodule : apf_checker

/* verif/async_parallel_fifo_port_test.sv */
`timescale 1ns/100ps
`include "apf_regs.svh"

module async_parallel_fifo_port_test;
  localparam int N = 120;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [7:0] h_tx_data = 8'h00, h_rx_data, d_tx_data, d_rx_data = 8'h00;
  logic [7:0] b_tx_data, b_rx_data = 8'h00;
  logic       h_tx_valid = 1'b0, h_tx_ready, h_rx_valid, h_rx_ready = 1'b0;
  logic       d_tx_valid, d_tx_ready = 1'b0, d_rx_valid = 1'b0, d_rx_ready;
  logic       b_tx_valid, b_tx_ready = 1'b0, b_rx_valid = 1'b0, b_rx_ready;
  logic       run = 1'b0, stall = 1'b0, h_acc = 1'b0, r_acc = 1'b0;
  logic [7:0] q_w[$], q_r[$], q_b[$];
  int         seed = 7788, r, n_w, n_r, cnt, err_total, checks;

  apf_if dut_if ();
  apf_if bad_if ();

  apf_host i_apf_host (.clk(clk), .sys_rst(sys_rst), .port(dut_if),
    .tx_data(h_tx_data), .tx_valid(h_tx_valid), .tx_ready(h_tx_ready),
    .rx_data(h_rx_data), .rx_valid(h_rx_valid), .rx_ready(h_rx_ready));
  apf_dev i_apf_dev (.clk(clk), .sys_rst(sys_rst), .port(dut_if),
    .tx_data(d_tx_data), .tx_valid(d_tx_valid), .tx_ready(d_tx_ready),
    .rx_data(d_rx_data), .rx_valid(d_rx_valid), .rx_ready(d_rx_ready));
  // Port driven straight by the bench, rules broken on purpose
  apf_dev i_apf_dev_b (.clk(clk), .sys_rst(sys_rst), .port(bad_if),
    .tx_data(b_tx_data), .tx_valid(b_tx_valid), .tx_ready(b_tx_ready),
    .rx_data(b_rx_data), .rx_valid(b_rx_valid), .rx_ready(b_rx_ready));
  apf_checker i_apf_checker (.clk(clk), .sys_rst(sys_rst),
    .data_dev(dut_if.data_dev), .data_dev_oe(dut_if.data_dev_oe),
    .data_host(dut_if.data_host), .data_host_oe(dut_if.data_host_oe),
    .data_bus(dut_if.data_bus), .rd_n(dut_if.rd_n), .wr_n(dut_if.wr_n),
    .rxf_n(dut_if.rxf_n), .txe_n(dut_if.txe_n));

  always #5 clk = ~clk;

  function automatic logic [7:0] b_byte(input int i);
    return 8'h5a ^ i[7:0];
  endfunction : b_byte

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic b_wr(input logic [7:0] v);
    @(negedge clk);
    bad_if.data_host = v;
    bad_if.data_host_oe = 1'b1;
    @(negedge clk);
    bad_if.wr_n = 1'b0;
    repeat (3) @(negedge clk);
    bad_if.wr_n = 1'b1;
    @(negedge clk);
    bad_if.data_host_oe = 1'b0;
    repeat (2) @(negedge clk);
  endtask : b_wr

  task automatic b_rd(input logic [7:0] v);
    @(negedge clk);
    bad_if.rd_n = 1'b0;
    @(negedge clk);
    check(bad_if.data_bus, v);
    check(bad_if.data_dev_oe, 1'b1);
    repeat (2) @(negedge clk);
    bad_if.rd_n = 1'b1;
    @(negedge clk);
    check(bad_if.data_dev_oe, 1'b0);
    check(bad_if.rxf_n, 1'b1);
  endtask : b_rd

  task automatic wait_rxf();
    cnt = 0;
    while (bad_if.rxf_n !== 1'b0 && cnt < 20) begin
      @(negedge clk);
      cnt++;
    end
  endtask : wait_rxf

  always @(posedge clk) begin
    h_acc = h_tx_valid && h_tx_ready;
    r_acc = d_rx_valid && d_rx_ready;
    n_w += h_acc;
    n_r += r_acc;
    if (h_acc) q_w.push_back(h_tx_data);
    if (r_acc) q_r.push_back(d_rx_data);
    if (d_tx_valid && d_tx_ready)
      check(d_tx_data, q_w.size() ? q_w.pop_front() : 8'hxx);
    if (h_rx_valid && h_rx_ready)
      check(h_rx_data, q_r.size() ? q_r.pop_front() : 8'hxx);
    if (b_tx_valid && b_tx_ready)
      check(b_tx_data, q_b.size() ? q_b.pop_front() : 8'hxx);
  end

  always @(negedge clk) begin
    r = $random(seed);
    if (h_acc || !h_tx_valid) begin
      h_tx_valid <= run && r[0] && n_w < N;
      h_tx_data  <= r[15:8];
    end
    if (r_acc || !d_rx_valid) begin
      d_rx_valid <= run && r[1] && n_r < N;
      d_rx_data  <= r[23:16];
    end
    d_tx_ready <= r[2] && !stall;
    h_rx_ready <= r[3] && !stall;
  end

  initial begin
    bad_if.rd_n = 1'b1;
    bad_if.wr_n = 1'b1;
    bad_if.data_host = 8'h00;
    bad_if.data_host_oe = 1'b0;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    // Both far sides stall until the buffers refuse
    stall = 1'b1;
    run = 1'b1;
    repeat (300) @(negedge clk);
    check(dut_if.txe_n, 1'b1);
    check(dut_if.rxf_n, 1'b0);
    check(d_rx_ready, 1'b0);
    stall = 1'b0;
    cnt = 0;
    while ((n_w < N || n_r < N || q_w.size() || q_r.size()) && cnt < 30000)
    begin
      @(negedge clk);
      cnt++;
    end
    check(8'(q_w.size() + q_r.size()), 8'h00);
    check(8'(n_w + n_r), 8'(2 * N));
    // Seventeenth write lands on a full buffer
    for (int i = 0; i < 17; i++) begin
      b_wr(b_byte(i));
      if (i < 16) q_b.push_back(b_byte(i));
      check(bad_if.txe_n, i >= 15);
    end
    b_tx_ready = 1'b1;
    repeat (25) @(negedge clk);
    check(8'(q_b.size()), 8'h00);
    check(b_tx_valid, 1'b0);
    check(bad_if.txe_n, 1'b0);
    b_rd(8'h00);
    b_rx_data = 8'hc3;
    b_rx_valid = 1'b1;
    @(negedge clk);
    b_rx_data = 8'h3c;
    @(negedge clk);
    b_rx_valid = 1'b0;
    wait_rxf();
    check(bad_if.rxf_n, 1'b0);
    b_rd(8'hc3);
    wait_rxf();
    check(cnt >= `APF_RXF_HOLD_CYC && cnt <= 13, 1'b1);
    b_rd(8'h3c);
    b_rd(8'h3c);
    print_verdict();
  end

  // Span far beyond the longest expected run
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    print_verdict();
  end
endmodule : async_parallel_fifo_port_test
